/* File: epo_asserts.sv */
`timescale 1ns/10ps
module epo_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sample_i,
  input wire logic pulse_out_1_o,
  input wire logic pulse_out_3_o,
  input wire logic [2:0] energy_snap_o
);
  // ----------------------------------------
  // Bus and pulse pin checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  a_ack_answer: assert property (req |=> wb_ack_o) else $error("ack late");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req)) else $error("stray ack");
  a_ack_once: assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack long");
  a_rsvd_zero: assert property (wb_dat_o[31:15] == 17'h0) else $error("bit 15 up");
  a_dat_on_ack: assert property ($changed(wb_dat_o) |-> wb_ack_o) else $error("dat moved");
  a_pin_cause: assert property ($rose(pulse_out_1_o) |-> $past(sample_i, 2))
    else $error("pin rose alone");
  a_snap_cause: assert property (|energy_snap_o |-> $past(sample_i, 2))
    else $error("snap alone");
  a_pin_holds: assert property ($rose(pulse_out_1_o) |-> pulse_out_1_o[*8])
    else $error("pin short");
  // Frozen clock enable must stall the ack and pin one, a pulse in flight too
  a_ce_freeze: assert property (!ce_i |=> $stable(wb_ack_o) && $stable(pulse_out_1_o))
    else $error("ce ignored");
  cover property ($rose(pulse_out_3_o));
  cover property (req && wb_we_i);
  cover property (!ce_i ##1 ce_i);
endmodule
bind epo_top epo_asserts epo_asserts_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .sample_i(sample_i), .pulse_out_1_o(pulse_out_1_o),
  .pulse_out_3_o(pulse_out_3_o), .energy_snap_o(energy_snap_o));

/* File: epo_defines.svh */
`ifndef EPO_DEFINES_SVH
`define EPO_DEFINES_SVH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define EPO_ADR_CFG 32'h0000e610
`define EPO_ADR_INCL 32'h0000e620
`define EPO_ADR_STAT 32'h0000e624

// ---------------------------------------------------------------
// Configuration fields
// ---------------------------------------------------------------
`define EPO_CFG_SEL1_LSB 0
`define EPO_CFG_SEL2_LSB 3
`define EPO_CFG_SEL3_LSB 6
`define EPO_CFG_OFF_LSB 9
`define EPO_CFG_SNAP_LSB 12
`define EPO_CFG_RSVD_BIT 15
`define EPO_CFG_RST 16'h0e88
`define EPO_CFG_WMASK 16'h7fff
`define EPO_INCL_RST 16'h01ff
`define EPO_INCL_WMASK 16'h01ff

// ---------------------------------------------------------------
// Converter timing
// ---------------------------------------------------------------
`define EPO_CLK_MHZ 40
`define EPO_PULSE_NS 1000
`define EPO_PULSE_CYC ((`EPO_PULSE_NS * `EPO_CLK_MHZ + 999) / 1000)
`define EPO_DFC_THRESH 28'h0400000

`endif

/* File: epo_dfc.sv */
`timescale 1ns/10ps
`include "epo_defines.svh"

module epo_dfc (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic sample_i,
  input epo_pkg::epo_sum_t power_i,
  output logic pulse_o,
  output logic issued_o
);
  import epo_pkg::*;

  epo_acc_t acc_ff, nxt_acc;
  epo_wid_t wid_ff, nxt_wid;
  logic pulse_ff, nxt_pulse;
  logic issued_ff, nxt_issued;
  logic [25:0] mag;

  // ---------------------------------------------------------------
  // Accumulate magnitude, fire at threshold
  // ---------------------------------------------------------------
  always_comb begin
    mag = power_i[25] ? 26'(-power_i) : 26'(power_i);
    nxt_acc = acc_ff;
    nxt_wid = wid_ff;
    nxt_pulse = pulse_ff;
    nxt_issued = 1'b0;
    if (!run_i) begin
      // Reserved source: no signal, and no stale energy later
      nxt_acc = '0;
      nxt_wid = '0;
      nxt_pulse = 1'b0;
    end else begin
      if (sample_i) begin
        nxt_acc = acc_ff + epo_acc_t'(mag);
      end
      if (nxt_acc >= `EPO_DFC_THRESH) begin
        nxt_acc = nxt_acc - `EPO_DFC_THRESH;
        nxt_issued = 1'b1;
        nxt_pulse = 1'b1;
        nxt_wid = epo_wid_t'(`EPO_PULSE_CYC - 1);
      end else if (wid_ff != '0) begin
        nxt_wid = wid_ff - 6'h1;
      end else begin
        nxt_pulse = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_ff <= '0;
      wid_ff <= '0;
      pulse_ff <= 1'b0;
      issued_ff <= 1'b0;
    end else if (ce_i) begin
      acc_ff <= nxt_acc;
      wid_ff <= nxt_wid;
      pulse_ff <= nxt_pulse;
      issued_ff <= nxt_issued;
    end
  end

  assign pulse_o = pulse_ff;
  assign issued_o = issued_ff;
endmodule

/* File: epo_pkg.sv */
package epo_pkg;
  typedef enum logic [2:0] {
    EPO_SRC_TOT_ACT = 3'h0,
    EPO_SRC_TOT_REACT = 3'h1,
    EPO_SRC_APPARENT = 3'h2,
    EPO_SRC_FUND_ACT = 3'h3,
    EPO_SRC_FUND_REACT = 3'h4
  } epo_src_t;

  typedef logic signed [23:0] epo_pwr_t;
  typedef logic signed [25:0] epo_sum_t;
  typedef logic [27:0] epo_acc_t;
  typedef logic [5:0] epo_wid_t;
endpackage

/* File: epo_pulse_counter.sv */
`timescale 1ns/10ps
module epo_pulse_counter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] pin_i,
  output logic [7:0] cnt_o [3]
);
  // ----------------------------------------
  // Rising edge counter per pin
  // ----------------------------------------
  logic [2:0] last_ff;
  always_ff @(posedge clk_i) begin
    last_ff <= pin_i;
    for (int k = 0; k < 3; k++) begin
      if (rst_i) cnt_o[k] <= 8'h0;
      else if (pin_i[k] && !last_ff[k]) cnt_o[k] <= cnt_o[k] + 8'h1;
    end
  end
endmodule

/* File: epo_top.sv */
// Added by the designer: register access over Wishbone.
`timescale 1ns/10ps
`include "epo_defines.svh"

// Overview of operation
// RULE_01: Bits 2:0 pick output one source: active, reactive, apparent, fund active, fund reactive.
// RULE_02: Output one source codes 101, 110, 111 produce no signal at all.
// RULE_03: Bits 5:3 pick output two source, reset 001, over its included phases.
// RULE_04: Output two source codes 101, 110, 111 produce no signal.
// RULE_05: Bits 8:6 pick output three source, reset 010, over its included phases.
// RULE_06: Output three source codes 101, 110, 111 produce no signal.
// RULE_07: Bit 9, reset 1, holds pin one off; its converter keeps running.
// RULE_08: Bit 10, reset 1, holds pin two off; its converter keeps running.
// RULE_09: Bit 11, reset 1, holds pin three off; its converter keeps running.
// RULE_10: Bit 12 set latches output one energy registers at each pulse; resets 0.
// RULE_11: Bit 13 set latches output two energy registers at each pulse; resets 0.
// RULE_12: Bit 14 set latches output three energy registers at each pulse; resets 0.
// RULE_13: Bit 15 resets to 0 and affects nothing.
// RULE_14: A phase adds into an output sum only when its inclusion bit is set.

module epo_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sample_i,
  input epo_pkg::epo_pwr_t tot_act_pwr_i [3],
  input epo_pkg::epo_pwr_t tot_react_pwr_i [3],
  input epo_pkg::epo_pwr_t apparent_pwr_i [3],
  input epo_pkg::epo_pwr_t fund_act_pwr_i [3],
  input epo_pkg::epo_pwr_t fund_react_pwr_i [3],
  output logic pulse_out_1_o,
  output logic pulse_out_2_o,
  output logic pulse_out_3_o,
  output logic [2:0] energy_snap_o
);
  import epo_pkg::*;

  logic [15:0] cfg_ff, nxt_cfg;
  logic [15:0] incl_ff, nxt_incl;
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic [2:0] pin_ff, nxt_pin;
  logic [2:0] snap_ff, nxt_snap;
  logic [15:0] wmask;
  logic req;
  logic [2:0] run;
  logic [2:0] dfc_pulse;
  logic [2:0] dfc_issued;
  logic [2:0] pin_off;
  logic [2:0] snap_en;
  epo_src_t src [3];
  epo_sum_t sum [3];

  // ---------------------------------------------------------------
  // Field views
  // ---------------------------------------------------------------
  assign src[0] = epo_src_t'(cfg_ff[`EPO_CFG_SEL1_LSB +: 3]);
  assign src[1] = epo_src_t'(cfg_ff[`EPO_CFG_SEL2_LSB +: 3]);
  assign src[2] = epo_src_t'(cfg_ff[`EPO_CFG_SEL3_LSB +: 3]);
  assign pin_off = cfg_ff[`EPO_CFG_OFF_LSB +: 3];
  assign snap_en = cfg_ff[`EPO_CFG_SNAP_LSB +: 3];

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  assign req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_comb begin
    nxt_ack = req;
    nxt_cfg = cfg_ff;
    nxt_incl = incl_ff;
    nxt_rdat = rdat_ff;
    if (req && wb_we_i) begin
      if (wb_adr_i == `EPO_ADR_CFG) begin
        // Bit 15 stays zero and drives nothing
        nxt_cfg = (cfg_ff & ~(wmask & `EPO_CFG_WMASK)) |
                  (wb_dat_i[15:0] & wmask & `EPO_CFG_WMASK); // see RULE_13
      end
      if (wb_adr_i == `EPO_ADR_INCL) begin
        nxt_incl = (incl_ff & ~(wmask & `EPO_INCL_WMASK)) |
                   (wb_dat_i[15:0] & wmask & `EPO_INCL_WMASK);
      end
    end
    if (req && !wb_we_i) begin
      // Unmapped reads answer zero rather than stall the bus
      unique case (wb_adr_i)
        `EPO_ADR_CFG: nxt_rdat = {16'h0000, cfg_ff};
        `EPO_ADR_INCL: nxt_rdat = {16'h0000, incl_ff};
        `EPO_ADR_STAT: nxt_rdat = {23'h0, dfc_issued, run, pin_ff};
        default: nxt_rdat = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      cfg_ff <= `EPO_CFG_RST; // see RULE_03 see RULE_05
      incl_ff <= `EPO_INCL_RST;
      rdat_ff <= 32'h00000000;
    end else if (ce_i) begin
      ack_ff <= nxt_ack;
      cfg_ff <= nxt_cfg;
      incl_ff <= nxt_incl;
      rdat_ff <= nxt_rdat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // ---------------------------------------------------------------
  // Per-output sum and converter
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_out
      always_comb begin
        sum[g] = '0;
        run[g] = 1'b1;
        for (int p = 0; p < 3; p++) begin
          if (incl_ff[3 * g + p]) begin // see RULE_14
            unique case (src[g]) // see RULE_01
              EPO_SRC_TOT_ACT: sum[g] = sum[g] + epo_sum_t'(tot_act_pwr_i[p]);
              EPO_SRC_TOT_REACT: sum[g] = sum[g] + epo_sum_t'(tot_react_pwr_i[p]);
              EPO_SRC_APPARENT: sum[g] = sum[g] + epo_sum_t'(apparent_pwr_i[p]);
              EPO_SRC_FUND_ACT: sum[g] = sum[g] + epo_sum_t'(fund_act_pwr_i[p]);
              EPO_SRC_FUND_REACT: sum[g] = sum[g] + epo_sum_t'(fund_react_pwr_i[p]);
              default: sum[g] = sum[g];
            endcase
          end
        end
        // Codes above the five sources stop the converter
        if (cfg_ff[3 * g +: 3] > 3'h4) begin
          run[g] = 1'b0; // see RULE_02 see RULE_04 see RULE_06
        end
      end

      epo_dfc u_dfc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .run_i(run[g]),
        .sample_i(sample_i),
        .power_i(sum[g]),
        .pulse_o(dfc_pulse[g]),
        .issued_o(dfc_issued[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Pin gating and energy snapshot strobes
  // ---------------------------------------------------------------
  always_comb begin
    // Gate only the pin, so the converter phase is kept across off
    nxt_pin = dfc_pulse & ~pin_off; // see RULE_07 see RULE_08 see RULE_09
    nxt_snap = dfc_issued & snap_en; // see RULE_10 see RULE_11 see RULE_12
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_ff <= 3'h0;
      snap_ff <= 3'h0;
    end else if (ce_i) begin
      pin_ff <= nxt_pin;
      snap_ff <= nxt_snap;
    end
  end

  assign pulse_out_1_o = pin_ff[0];
  assign pulse_out_2_o = pin_ff[1];
  assign pulse_out_3_o = pin_ff[2];
  assign energy_snap_o = snap_ff;
endmodule

/* File: testbench.sv */
`timescale 1ns/10ps
`include "epo_defines.svh"
module testbench;
  import epo_pkg::*;
  typedef struct {logic [15:0] cfg, incl; logic [2:0] pin, snp;} epo_row_t;
  logic clk_i = 0, rst_i = 1, ce_i = 1, cyc = 0, stb = 0, we = 0, smp = 0;
  logic [31:0] adr = 32'h0, dat = 32'h0, dat_o, q;
  logic ack, p1, p2, p3;
  logic [2:0] snap;
  logic [7:0] cnt [3];
  epo_pwr_t ta [3] = '{24'h400000, 24'h0, 24'h0};
  epo_pwr_t tr [3] = '{24'h0, 24'h400000, 24'h0};
  epo_pwr_t ap [3] = '{24'h0, 24'h0, 24'h400000};
  epo_pwr_t fa [3] = '{24'h200000, 24'h200000, 24'h0};
  epo_pwr_t fr [3] = '{24'h0, 24'h0, 24'h400000};
  int fails = 0, checks = 0, cyc_n = 0, n, ecnt = 0;
  epo_row_t rows [7] = '{'{16'h7088, 16'h01ff, 3'h7, 3'h7}, '{16'h7163, 16'h01ff, 3'h3, 3'h3},
    '{16'h7088, 16'h01fe, 3'h6, 3'h6}, '{16'h7288, 16'h01ff, 3'h6, 3'h7},
    '{16'h0088, 16'h01ff, 3'h7, 3'h0}, '{16'hf1be, 16'h01ff, 3'h0, 3'h0},
    '{16'h7088, 16'h01ef, 3'h5, 3'h5}};
  always #12.5 clk_i = ~clk_i;
  epo_top epo_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .sample_i(smp), .tot_act_pwr_i(ta),
    .tot_react_pwr_i(tr), .apparent_pwr_i(ap), .fund_act_pwr_i(fa), .fund_react_pwr_i(fr),
    .pulse_out_1_o(p1), .pulse_out_2_o(p2), .pulse_out_3_o(p3), .energy_snap_o(snap));
  epo_pulse_counter epo_pulse_counter_i (.clk_i(clk_i), .rst_i(rst_i),
    .pin_i({p3, p2, p1}), .cnt_o(cnt));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, e, input string m);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    int k;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) chk(0, 1, "no ack");
    r = dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  // Snap stands one cycle only, so look in the cycle the pin rises
  task automatic fire;
    @(posedge clk_i) smp <= 1;
    @(posedge clk_i) smp <= 0;
    @(posedge clk_i);
    #1;
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      fails++;
      close_out;
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 32'he610, 0, q);
    chk(q, 32'h0e88, "cfg rst");
    wb(0, 32'he614, 0, q);
    chk(q, 0, "unmapped");
    wb(0, 32'he624, 0, q);
    chk(q, 32'h38, "status");
    $display("reset test done");
    foreach (rows[i]) begin
      // Refused codes clear converters so no residue leaks between rows
      wb(1, 32'he610, 32'h0fff, q);
      wb(1, 32'he620, rows[i].incl, q);
      wb(1, 32'he610, rows[i].cfg, q);
      wb(0, 32'he610, 0, q);
      chk(q, rows[i].cfg & 16'h7fff, "cfg rd");
      fire;
      chk({p3, p2, p1}, rows[i].pin, "pins");
      chk(snap, rows[i].snp, "snap");
      ecnt += $countones(rows[i].pin);
      repeat (45) @(posedge clk_i);
      $display("row %0d done", i);
    end
    chk(32'(cnt[0]) + cnt[1] + cnt[2], ecnt, "count");
    wb(1, 32'he610, 32'h0fff, q);
    wb(1, 32'he610, 32'h0088, q);
    fire;
    n = 0;
    while (p1 === 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
      if (n == 10) ce_i <= 0;
      if (n == 15) ce_i <= 1;
    end
    chk(n, `EPO_PULSE_CYC + 6, "width");
    $display("width test done");
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 32'he610, 0, q);
    chk(q, 32'h0e88, "cfg rst2");
    wb(0, 32'he620, 0, q);
    chk(q, 32'h01ff, "incl rst");
    $display("second reset done");
    close_out;
  end
endmodule
